// ===== hdl/dsfb_bank.v
/*
  Diagnostic status/control byte and alarm/warning flag bank of a
  pluggable transceiver, with the live measurement bytes and the preset
  threshold bytes that the flags are judged against.
  Assumes the serial management front end turns bus cycles into one-cycle
  byte read and write strobes on this clock, and that the measurement
  engine presents all five values with a one-cycle update strobe.
*/
// Summary of operation
// - Bit 7 reports transmit-disable state
// - Bit 6 read/write soft transmit disable
// - Bit 1 mirrors receive loss pin
// - Bit 0 low when data ready
// - Byte 112 bits 7,6: temperature alarms
// - Byte 112 bits 5,4: supply alarms
// - Byte 112 bits 3,2: bias alarms
// - Byte 112 bits 1,0: transmit power alarms
// - Byte 113 bits 7,6: receive power alarms
// - Byte 116 bits 7,6: temperature warnings
// - Byte 116 bits 5,4: supply warnings
// - Byte 116 bits 3,2: bias warnings
// - Byte 116 bits 1,0: transmit power warnings
// - Byte 117 bits 7,6: receive power warnings
// - Fixed preset alarm and warning thresholds
// - Temperature signed, 1/256 degree steps
// - Measurements at bytes 96-105, MSB first
`timescale 1ns/100ps
`default_nettype none
`include "dsfb_regs.vh"

module dsfb_bank (
  input wire mclk_i,
  input wire arst_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  input wire tx_disable_pin_i,
  input wire receive_signal_lost_i,
  input wire powered_i,
  input wire meas_update_i,
  input wire [15:0] meas_temp_i,
  input wire [15:0] meas_vcc_i,
  input wire [15:0] meas_bias_i,
  input wire [15:0] meas_txp_i,
  input wire [15:0] meas_rxp_i,
  output reg tx_disable_o,
  output reg data_ready_n_o
);

  // ----------------------------------------------------------------------
  // Byte picking helpers
  // ----------------------------------------------------------------------
  // Even address gives the most significant byte
  function [7:0] word_byte;
    input [15:0] w;
    input odd;
    begin
      word_byte = odd ? w[7:0] : w[15:8];
    end
  endfunction

  // Preset threshold word by word index of bytes 0..39
  function [15:0] thr_word;
    input [4:0] idx;
    begin
      case (idx)
        5'd0: thr_word = `DSFB_TEMP_HA;
        5'd1: thr_word = `DSFB_TEMP_LA;
        5'd2: thr_word = `DSFB_TEMP_HW;
        5'd3: thr_word = `DSFB_TEMP_LW;
        5'd4: thr_word = `DSFB_VCC_HA;
        5'd5: thr_word = `DSFB_VCC_LA;
        5'd6: thr_word = `DSFB_VCC_HW;
        5'd7: thr_word = `DSFB_VCC_LW;
        5'd8: thr_word = `DSFB_BIAS_HA;
        5'd9: thr_word = `DSFB_BIAS_LA;
        5'd10: thr_word = `DSFB_BIAS_HW;
        5'd11: thr_word = `DSFB_BIAS_LW;
        5'd12: thr_word = `DSFB_TXP_HA;
        5'd13: thr_word = `DSFB_TXP_LA;
        5'd14: thr_word = `DSFB_TXP_HW;
        5'd15: thr_word = `DSFB_TXP_LW;
        5'd16: thr_word = `DSFB_RXP_HA;
        5'd17: thr_word = `DSFB_RXP_LA;
        5'd18: thr_word = `DSFB_RXP_HW;
        5'd19: thr_word = `DSFB_RXP_LW;
        default: thr_word = 16'h0000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg soft_txdis_q;
  reg txdis_state_q;
  reg receive_signal_lost_state_q;
  reg [7:0] alarm_flags_a_q;
  reg [7:0] alarm_flags_b_q;
  reg [7:0] warning_flags_a_q;
  reg [7:0] warning_flags_b_q;
  reg [15:0] temp_q;
  reg [15:0] vcc_q;
  reg [15:0] bias_q;
  reg [15:0] txp_q;
  reg [15:0] rxp_q;
  reg [7:0] rdata_d;
  reg [7:0] meas_byte;
  reg [7:0] alarm_a_d;
  reg [7:0] alarm_b_d;
  reg [7:0] warn_a_d;
  reg [7:0] warn_b_d;
  wire [7:0] status_control;
  wire [3:0] temp_cmp;
  wire [3:0] vcc_cmp;
  wire [3:0] bias_cmp;
  wire [3:0] txp_cmp;
  wire [3:0] rxp_cmp;

  // ----------------------------------------------------------------------
  // Limit comparators, judged on the incoming measurement
  // ----------------------------------------------------------------------
  // Temperature compares signed
  dsfb_limit_cmp #(
    .SIGNED_CMP(1),
    .HI_ALARM(`DSFB_TEMP_HA),
    .LO_ALARM(`DSFB_TEMP_LA),
    .HI_WARN(`DSFB_TEMP_HW),
    .LO_WARN(`DSFB_TEMP_LW)
  ) u_cmp_temp (
    .value_i(meas_temp_i),
    .hi_alarm_o(temp_cmp[3]),
    .lo_alarm_o(temp_cmp[2]),
    .hi_warn_o(temp_cmp[1]),
    .lo_warn_o(temp_cmp[0])
  );

  // Supply voltage
  dsfb_limit_cmp #(
    .SIGNED_CMP(0),
    .HI_ALARM(`DSFB_VCC_HA),
    .LO_ALARM(`DSFB_VCC_LA),
    .HI_WARN(`DSFB_VCC_HW),
    .LO_WARN(`DSFB_VCC_LW)
  ) u_cmp_vcc (
    .value_i(meas_vcc_i),
    .hi_alarm_o(vcc_cmp[3]),
    .lo_alarm_o(vcc_cmp[2]),
    .hi_warn_o(vcc_cmp[1]),
    .lo_warn_o(vcc_cmp[0])
  );

  // LED bias current
  dsfb_limit_cmp #(
    .SIGNED_CMP(0),
    .HI_ALARM(`DSFB_BIAS_HA),
    .LO_ALARM(`DSFB_BIAS_LA),
    .HI_WARN(`DSFB_BIAS_HW),
    .LO_WARN(`DSFB_BIAS_LW)
  ) u_cmp_bias (
    .value_i(meas_bias_i),
    .hi_alarm_o(bias_cmp[3]),
    .lo_alarm_o(bias_cmp[2]),
    .hi_warn_o(bias_cmp[1]),
    .lo_warn_o(bias_cmp[0])
  );

  // Transmit average power
  dsfb_limit_cmp #(
    .SIGNED_CMP(0),
    .HI_ALARM(`DSFB_TXP_HA),
    .LO_ALARM(`DSFB_TXP_LA),
    .HI_WARN(`DSFB_TXP_HW),
    .LO_WARN(`DSFB_TXP_LW)
  ) u_cmp_txp (
    .value_i(meas_txp_i),
    .hi_alarm_o(txp_cmp[3]),
    .lo_alarm_o(txp_cmp[2]),
    .hi_warn_o(txp_cmp[1]),
    .lo_warn_o(txp_cmp[0])
  );

  // Receive average power
  dsfb_limit_cmp #(
    .SIGNED_CMP(0),
    .HI_ALARM(`DSFB_RXP_HA),
    .LO_ALARM(`DSFB_RXP_LA),
    .HI_WARN(`DSFB_RXP_HW),
    .LO_WARN(`DSFB_RXP_LW)
  ) u_cmp_rxp (
    .value_i(meas_rxp_i),
    .hi_alarm_o(rxp_cmp[3]),
    .lo_alarm_o(rxp_cmp[2]),
    .hi_warn_o(rxp_cmp[1]),
    .lo_warn_o(rxp_cmp[0])
  );

  // ----------------------------------------------------------------------
  // Next flag bytes, reserved bits forced low
  // ----------------------------------------------------------------------
  always @* begin
    alarm_a_d = `DSFB_RST_FLAGS;
    alarm_b_d = `DSFB_RST_FLAGS;
    warn_a_d = `DSFB_RST_FLAGS;
    warn_b_d = `DSFB_RST_FLAGS;
    alarm_a_d[`DSFB_FL_TEMP_HI] = temp_cmp[3];
    alarm_a_d[`DSFB_FL_TEMP_LO] = temp_cmp[2];
    alarm_a_d[`DSFB_FL_VCC_HI] = vcc_cmp[3];
    alarm_a_d[`DSFB_FL_VCC_LO] = vcc_cmp[2];
    alarm_a_d[`DSFB_FL_BIAS_HI] = bias_cmp[3];
    alarm_a_d[`DSFB_FL_BIAS_LO] = bias_cmp[2];
    alarm_a_d[`DSFB_FL_TXP_HI] = txp_cmp[3];
    alarm_a_d[`DSFB_FL_TXP_LO] = txp_cmp[2];
    alarm_b_d[`DSFB_FL_RXP_HI] = rxp_cmp[3];
    alarm_b_d[`DSFB_FL_RXP_LO] = rxp_cmp[2];
    warn_a_d[`DSFB_FL_TEMP_HI] = temp_cmp[1];
    warn_a_d[`DSFB_FL_TEMP_LO] = temp_cmp[0];
    warn_a_d[`DSFB_FL_VCC_HI] = vcc_cmp[1];
    warn_a_d[`DSFB_FL_VCC_LO] = vcc_cmp[0];
    warn_a_d[`DSFB_FL_BIAS_HI] = bias_cmp[1];
    warn_a_d[`DSFB_FL_BIAS_LO] = bias_cmp[0];
    warn_a_d[`DSFB_FL_TXP_HI] = txp_cmp[1];
    warn_a_d[`DSFB_FL_TXP_LO] = txp_cmp[0];
    warn_b_d[`DSFB_FL_RXP_HI] = rxp_cmp[1];
    warn_b_d[`DSFB_FL_RXP_LO] = rxp_cmp[0];
  end

  // ----------------------------------------------------------------------
  // Measurement and flag capture
  // ----------------------------------------------------------------------
  // Whole set replaced per update so flags also clear; host writes never reach here
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      temp_q <= `DSFB_RST_MEAS;
      vcc_q <= `DSFB_RST_MEAS;
      bias_q <= `DSFB_RST_MEAS;
      txp_q <= `DSFB_RST_MEAS;
      rxp_q <= `DSFB_RST_MEAS;
      alarm_flags_a_q <= `DSFB_RST_FLAGS;
      alarm_flags_b_q <= `DSFB_RST_FLAGS;
      warning_flags_a_q <= `DSFB_RST_FLAGS;
      warning_flags_b_q <= `DSFB_RST_FLAGS;
    end else if (meas_update_i) begin
      temp_q <= meas_temp_i;
      vcc_q <= meas_vcc_i;
      bias_q <= meas_bias_i;
      txp_q <= meas_txp_i;
      rxp_q <= meas_rxp_i;
      alarm_flags_a_q <= alarm_a_d;
      alarm_flags_b_q <= alarm_b_d;
      warning_flags_a_q <= warn_a_d;
      warning_flags_b_q <= warn_b_d;
    end
  end

  // ----------------------------------------------------------------------
  // Status/control byte
  // ----------------------------------------------------------------------
  // Soft disable bit is the only host-writable bit
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_txdis_q <= `DSFB_RST_SOFT_TXDIS;
    end else if (reg_wr_i && reg_addr_i == `DSFB_STATUS_CONTROL) begin
      soft_txdis_q <= reg_wdata_i[`DSFB_SC_SOFT_TXDIS];
    end
  end

  // Pin states and ready flag
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txdis_state_q <= 1'b0;
      tx_disable_o <= 1'b0;
      receive_signal_lost_state_q <= 1'b0;
      data_ready_n_o <= `DSFB_RST_DATA_READY_N;
    end else begin
      txdis_state_q <= soft_txdis_q | tx_disable_pin_i;
      tx_disable_o <= soft_txdis_q | tx_disable_pin_i;
      receive_signal_lost_state_q <= receive_signal_lost_i;
      if (!powered_i) begin
        data_ready_n_o <= 1'b1;
      end else if (meas_update_i) begin
        data_ready_n_o <= 1'b0;
      end
    end
  end

  // Assembled byte, reserved bits 5..2 zero
  assign status_control = {txdis_state_q, soft_txdis_q, 4'h0,
                           receive_signal_lost_state_q, data_ready_n_o};

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  // Live measurement bytes 96..105
  always @* begin
    case (reg_addr_i[3:1])
      3'd0: meas_byte = word_byte(temp_q, reg_addr_i[0]);
      3'd1: meas_byte = word_byte(vcc_q, reg_addr_i[0]);
      3'd2: meas_byte = word_byte(bias_q, reg_addr_i[0]);
      3'd3: meas_byte = word_byte(txp_q, reg_addr_i[0]);
      3'd4: meas_byte = word_byte(rxp_q, reg_addr_i[0]);
      default: meas_byte = 8'h00;
    endcase
  end

  // Whole page, unmapped bytes read zero
  always @* begin
    if (reg_addr_i <= `DSFB_THR_LAST) begin
      rdata_d = word_byte(thr_word(reg_addr_i[5:1]), reg_addr_i[0]);
    end else if (reg_addr_i >= `DSFB_MEAS_FIRST && reg_addr_i <= `DSFB_MEAS_LAST) begin
      rdata_d = meas_byte;
    end else begin
      case (reg_addr_i)
        `DSFB_STATUS_CONTROL: rdata_d = status_control;
        `DSFB_ALARM_FLAGS_A: rdata_d = alarm_flags_a_q;
        `DSFB_ALARM_FLAGS_B: rdata_d = alarm_flags_b_q;
        `DSFB_WARNING_FLAGS_A: rdata_d = warning_flags_a_q;
        `DSFB_WARNING_FLAGS_B: rdata_d = warning_flags_b_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data registered one cycle after the strobe
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

endmodule // dsfb_bank

`default_nettype wire

// ===== hdl/dsfb_limit_cmp.v
/*
  Four-way limit comparator: one live measurement against its high and
  low alarm and warning thresholds.
  Assumes thresholds are constants and the value is stable when sampled.
*/
`timescale 1ns/100ps
`default_nettype none

module dsfb_limit_cmp #(
  parameter SIGNED_CMP = 0,
  parameter [15:0] HI_ALARM = 16'h0000,
  parameter [15:0] LO_ALARM = 16'h0000,
  parameter [15:0] HI_WARN = 16'h0000,
  parameter [15:0] LO_WARN = 16'h0000
) (
  input wire [15:0] value_i,
  output wire hi_alarm_o,
  output wire lo_alarm_o,
  output wire hi_warn_o,
  output wire lo_warn_o
);

  // ----------------------------------------------------------------------
  // Order-preserving key: flipping the sign bit makes signed compare unsigned
  // ----------------------------------------------------------------------
  function [15:0] key;
    input [15:0] v;
    begin
      key = (SIGNED_CMP != 0) ? {~v[15], v[14:0]} : v;
    end
  endfunction

  // High flags above the high limit, low flags below the low limit
  assign hi_alarm_o = key(value_i) > key(HI_ALARM);
  assign lo_alarm_o = key(value_i) < key(LO_ALARM);
  assign hi_warn_o = key(value_i) > key(HI_WARN);
  assign lo_warn_o = key(value_i) < key(LO_WARN);

endmodule // dsfb_limit_cmp

`default_nettype wire

// ===== hdl/dsfb_regs.vh
/*
  Register offsets, field positions, reset values and preset threshold
  codes of the diagnostic status and flag bank.
  Assumes byte addressing of the diagnostic page, offsets in hexadecimal bytes.
*/
`ifndef DSFB_REGS_VH
`define DSFB_REGS_VH

// ----------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------
`define DSFB_THR_FIRST 8'h00
`define DSFB_THR_LAST 8'h27
`define DSFB_MEAS_FIRST 8'h60
`define DSFB_MEAS_LAST 8'h69
`define DSFB_STATUS_CONTROL 8'h6E
`define DSFB_ALARM_FLAGS_A 8'h70
`define DSFB_ALARM_FLAGS_B 8'h71
`define DSFB_WARNING_FLAGS_A 8'h74
`define DSFB_WARNING_FLAGS_B 8'h75

// ----------------------------------------------------------------------
// Status/control bit positions
// ----------------------------------------------------------------------
`define DSFB_SC_TXDIS_STATE 7
`define DSFB_SC_SOFT_TXDIS 6
`define DSFB_SC_RXLOS_STATE 1
`define DSFB_SC_DATA_READY_N 0

// ----------------------------------------------------------------------
// Flag bit positions inside a flag byte pair
// ----------------------------------------------------------------------
`define DSFB_FL_TEMP_HI 7
`define DSFB_FL_TEMP_LO 6
`define DSFB_FL_VCC_HI 5
`define DSFB_FL_VCC_LO 4
`define DSFB_FL_BIAS_HI 3
`define DSFB_FL_BIAS_LO 2
`define DSFB_FL_TXP_HI 1
`define DSFB_FL_TXP_LO 0
`define DSFB_FL_RXP_HI 7
`define DSFB_FL_RXP_LO 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSFB_RST_SOFT_TXDIS 1'b0
`define DSFB_RST_DATA_READY_N 1'b1
`define DSFB_RST_FLAGS 8'h00
`define DSFB_RST_MEAS 16'h0000

// ----------------------------------------------------------------------
// Preset thresholds, coded as the live measurements
// Temp 1/256 C signed, Vcc 100 uV, bias 2 uA, power 0.1 uW
// ----------------------------------------------------------------------
`define DSFB_TEMP_HA 16'h5500
`define DSFB_TEMP_LA 16'hD800
`define DSFB_TEMP_HW 16'h5000
`define DSFB_TEMP_LW 16'hDD00
`define DSFB_VCC_HA 16'h8CA0
`define DSFB_VCC_LA 16'h7530
`define DSFB_VCC_HW 16'h88B8
`define DSFB_VCC_LW 16'h7918
`define DSFB_BIAS_HA 16'hEA60
`define DSFB_BIAS_LA 16'h1388
`define DSFB_BIAS_HW 16'hD6D8
`define DSFB_BIAS_LW 16'h1D4C
`define DSFB_TXP_HA 16'h031A
`define DSFB_TXP_LA 16'h0032
`define DSFB_TXP_HW 16'h0277
`define DSFB_TXP_LW 16'h003F
`define DSFB_RXP_HA 16'h031A
`define DSFB_RXP_LA 16'h0005
`define DSFB_RXP_HW 16'h0277
`define DSFB_RXP_LW 16'h0006

`endif

// ===== verif/dsfb_bank_props.sv
/*
  Port checker for the diagnostic status and flag bank.
  Assumes it is bound onto dsfb_bank and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsfb_regs.vh"

module dsfb_bank_props (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic tx_disable_pin_i,
  input wire logic receive_signal_lost_i,
  input wire logic powered_i,
  input wire logic meas_update_i,
  input wire logic tx_disable_o,
  input wire logic data_ready_n_o
);
  // ----------------------------------------------------------------
  // Bus answers and status behaviour
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe got no valid pulse");
  a_rvalid_caused: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("valid pulse without read strobe");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_pin_disables: assert property (tx_disable_pin_i |=> tx_disable_o)
    else $error("disable pin not reflected");
  a_soft_disable: assert property (reg_wr_i && reg_addr_i == `DSFB_STATUS_CONTROL && reg_wdata_i[6]
    |-> ##2 tx_disable_o)
    else $error("soft disable write had no effect");
  a_ready_on_update: assert property (meas_update_i && powered_i |=> !data_ready_n_o)
    else $error("ready not shown after update");
  a_unpowered_busy: assert property (!powered_i |=> data_ready_n_o)
    else $error("ready shown while unpowered");
  a_los_mirror: assert property (reg_rd_i && reg_addr_i == `DSFB_STATUS_CONTROL && receive_signal_lost_i
    && $past(receive_signal_lost_i) && $past(arst_n_i) |=> reg_rdata_o[1])
    else $error("loss of signal not in status");
  a_reserved_zero: assert property (reg_rvalid_o && ($past(reg_addr_i) == `DSFB_ALARM_FLAGS_B
    || $past(reg_addr_i) == `DSFB_WARNING_FLAGS_B) |-> reg_rdata_o[5:0] == 6'h00)
    else $error("reserved flag bits not zero");
endmodule // dsfb_bank_props

bind dsfb_bank dsfb_bank_props chk_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .tx_disable_pin_i(tx_disable_pin_i),
  .receive_signal_lost_i(receive_signal_lost_i), .powered_i(powered_i), .meas_update_i(meas_update_i),
  .tx_disable_o(tx_disable_o), .data_ready_n_o(data_ready_n_o));
`default_nettype wire

// ===== verif/dsfb_host.sv
/*
  Host controller model: byte reads and writes of the diagnostic page.
  Assumes one-cycle strobes on the bank clock, answer one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none

module dsfb_host (
  input wire logic mclk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output var logic [7:0] reg_addr_o,
  output var logic [7:0] reg_wdata_o,
  output var logic reg_wr_o,
  output var logic reg_rd_o
);
  // Idle bus
  initial begin
    reg_addr_o = 8'hFF;
    reg_wdata_o = 8'hFF;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // Byte write, lines inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  // Byte read, bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge mclk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    n = 0;
    while (reg_rvalid_i !== 1'b1 && n < 4) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
  endtask
endmodule // dsfb_host
`default_nettype wire

// ===== verif/tb_top.sv
/*
  Self-checking bench for the diagnostic status and flag bank.
  Assumes the host model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dsfb_regs.vh"

module tb_top;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pin_q = 1'b0;
  logic los_q = 1'b0;
  logic pwr_q = 1'b1;
  logic upd_q = 1'b0;
  logic [79:0] meas_q = 80'h0; // Temp, vcc, bias, txp, rxp
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rvalid, txdis, rdy_n;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc_q = 0;
  localparam logic [79:0] nom_meas = {16'h1900, 16'h80E8, 16'h7530, 16'h0100, 16'h0100};

  always #25 mclk_i = ~mclk_i;

  dsfb_bank dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .tx_disable_pin_i(pin_q), .receive_signal_lost_i(los_q), .powered_i(pwr_q), .meas_update_i(upd_q),
    .meas_temp_i(meas_q[79:64]), .meas_vcc_i(meas_q[63:48]), .meas_bias_i(meas_q[47:32]),
    .meas_txp_i(meas_q[31:16]), .meas_rxp_i(meas_q[15:0]), .tx_disable_o(txdis), .data_ready_n_o(rdy_n));
  dsfb_host host_u (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk8($sformatf("byte %h", a), exp, d);
  endtask

  // One measurement k moved off nominal, then all four flag bytes
  task automatic tc(input int k, input logic [15:0] v, input logic [31:0] exp);
    logic [79:0] m;
    m = nom_meas;
    m[79-16*k -: 16] = v;
    @(posedge mclk_i);
    #1;
    meas_q = m;
    upd_q = 1'b1;
    @(posedge mclk_i);
    #1;
    upd_q = 1'b0;
    rdc(`DSFB_ALARM_FLAGS_A, exp[31:24]);
    rdc(`DSFB_ALARM_FLAGS_B, exp[23:16]);
    rdc(`DSFB_WARNING_FLAGS_A, exp[15:8]);
    rdc(`DSFB_WARNING_FLAGS_B, exp[7:0]);
  endtask

  // Hang guard
  always @(posedge mclk_i) begin
    cyc_q++;
    if (cyc_q == 3000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_i);
    #1;
    arst_n_i = 1'b1;
    rdc(`DSFB_STATUS_CONTROL, 8'h01);
    tc(0, 16'h1900, 32'h0);
    rdc(`DSFB_STATUS_CONTROL, 8'h00);
    tc(0, 16'h5501, 32'h8000_8000);
    tc(0, 16'h5500, 32'h0000_8000);
    tc(0, 16'hD7FF, 32'h4000_4000);
    rdc(8'h60, 8'hD7);
    rdc(8'h61, 8'hFF);
    tc(1, 16'h8CA1, 32'h2000_2000);
    tc(1, 16'h88B9, 32'h0000_2000);
    tc(1, 16'h752F, 32'h1000_1000);
    tc(2, 16'hEA61, 32'h0800_0800);
    tc(2, 16'h1387, 32'h0400_0400);
    tc(3, 16'h031B, 32'h0200_0200);
    tc(3, 16'h0031, 32'h0100_0100);
    tc(4, 16'h031B, 32'h0080_0080);
    tc(4, 16'h0004, 32'h0040_0040);
    tc(4, 16'h0100, 32'h0);
    tc(0, 16'h5501, 32'h8000_8000);
    host_u.wr(`DSFB_ALARM_FLAGS_A, 8'h00);
    host_u.wr(`DSFB_ALARM_FLAGS_B, 8'hFF);
    rdc(`DSFB_ALARM_FLAGS_A, 8'h80);
    rdc(`DSFB_ALARM_FLAGS_B, 8'h00);
    host_u.wr(8'h00, 8'h00);
    rdc(8'h00, 8'h55);
    rdc(8'h01, 8'h00);
    rdc(8'h23, 8'h05);
    rdc(8'h27, 8'h06);
    host_u.wr(`DSFB_STATUS_CONTROL, 8'hFF);
    @(posedge mclk_i);
    rdc(`DSFB_STATUS_CONTROL, 8'hC0);
    chk8("tx disable", 8'h01, {7'h00, txdis});
    host_u.wr(`DSFB_STATUS_CONTROL, 8'h00);
    @(posedge mclk_i);
    rdc(`DSFB_STATUS_CONTROL, 8'h00);
    pin_q = 1'b1;
    rdc(`DSFB_STATUS_CONTROL, 8'h80);
    chk8("tx disable", 8'h01, {7'h00, txdis});
    pin_q = 1'b0;
    los_q = 1'b1;
    rdc(`DSFB_STATUS_CONTROL, 8'h02);
    los_q = 1'b0;
    pwr_q = 1'b0;
    rdc(`DSFB_STATUS_CONTROL, 8'h01);
    chk8("ready low", 8'h01, {7'h00, rdy_n});
    pwr_q = 1'b1;
    tc(0, 16'h1900, 32'h0);
    rdc(`DSFB_STATUS_CONTROL, 8'h00);
    rdc(8'h80, 8'h00);
    rdc(8'h6F, 8'h00);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
